// ==== include/pmic_irq_defines.vh ====
/*
  Offsets, field positions, reset values and timing counts of the
  interrupt and protection block.
  Assumes a 40 MHz system clock and a 32-bit APB register bus.
*/
`ifndef PMIC_IRQ_DEFINES_VH
`define PMIC_IRQ_DEFINES_VH

// ************************************************************
// Register byte offsets
// ************************************************************
`define OFS_INT_TOP       12'h000
`define OFS_INT_BUCK      12'h004
`define OFS_INT_LDO       12'h008
`define OFS_MASK_TOP      12'h00C
`define OFS_MASK_BUCK     12'h010
`define OFS_MASK_LDO      12'h014
`define OFS_STAT          12'h018
`define OFS_CTRL          12'h01C
`define OFS_RESET         12'h020

// ************************************************************
// Top flag field positions (INT_TOP, MASK_TOP)
// ************************************************************
`define B_HOT_WARN        0
`define B_OVERTEMP        1
`define B_OVERVOLT        2
`define B_PIN_OK          3
`define B_CLK_CHANGE      4
`define B_MEAS_READY      5
`define B_RESET_OCC       6
`define B_BUCK_SUM        7
`define B_LDO_SUM         8

// Per-regulator fields: curlim [1:0], short [3:2], output ok [5:4].
`define B_CURLIM          0
`define B_SHORT           2
`define B_OUT_OK          4
// Mask fields: curlim [1:0], rise [3:2], fall [5:4].
`define B_RISE            2
`define B_FALL            4

// Status fields.
`define B_ST_BUCK_CL      0
`define B_ST_LDO_CL       2
`define B_ST_BUCK_OK      4
`define B_ST_LDO_OK       6
`define B_ST_HOT          8
`define B_ST_OVERTEMP     9
`define B_ST_OVERVOLT     10
`define B_ST_PIN_OK       11
`define B_ST_CLK          12

// Control fields.
`define B_POLARITY        0
`define B_CLKDET_EN       1

// ************************************************************
// Reset values
// ************************************************************
`define RST_MASK_TOP      9'h000
`define RST_MASK_REG      6'h00
`define RST_CTRL          2'h0

// ************************************************************
// Timing
// ************************************************************
`define CLK_HZ            40000000
`define SHORT_WAIT_US     1000
`define SHORT_WAIT_CYC    ((`CLK_HZ / 1000000) * `SHORT_WAIT_US)

`endif

// ==== hw/short_detector.v ====
/*
  Short-circuit detector for one regulator output.
  Assumes the low-output comparator and enable are already synchronised.
*/
`timescale 1ns/1ps

module short_detector #(
  parameter WAIT_CYCLES = 40000
) (
  // Clock and reset.
  input  wire clock,
  input  wire rst,
  // Regulator view.
  input  wire enabled,
  input  wire output_low,
  // Result.
  output reg  short_pulse
);

  reg [15:0] count;

  // One timer covers both cases: low since enable and low during
  // operation both need a full millisecond of being low before tripping.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      count       <= 16'h0000;
      short_pulse <= 1'b0;
    end else begin
      short_pulse <= 1'b0;
      if (!enabled || !output_low) begin
        count <= 16'h0000;
      end else if (count == WAIT_CYCLES[15:0] - 16'h0001) begin
        count       <= 16'h0000;
        short_pulse <= 1'b1;
      end else begin
        count <= count + 16'h0001;
      end
    end
  end

endmodule // short_detector

// ==== hw/pmic_protection_interrupts.v ====
/*
  Interrupt and protection logic of a dual buck / dual LDO power manager:
  sticky flags, masks, status, interrupt pin and shutdowns, over APB.
  Assumes asynchronous event inputs, synchronised here; the nonvolatile
  reset mask is a level from outside.
*/
`timescale 1ns/1ps
`include "pmic_irq_defines.vh"

// Overview of operation
// - Any protection or warning event sets its flag and, unless masked, pulls the pin low.
// - Interrupt pin stays low while any unmasked flag is pending.
// - Undervoltage or soft reset sets reset-occurred flag on next start unless masked; fault shutdown does not.
// - Reset mask comes from nonvolatile level at reset; writes ignored.
// - Buck current limit flag, maskable, live status, sticks while active.
// - LDO current limit flag, maskable, live status, sticks while active.
// - Buck low after one millisecond disables buck, sets short flag.
// - LDO low after one millisecond disables LDO, sets short flag.
// - Hot warning flag maskable, live status, sticks while hot.
// - Overtemperature disables all, outputs low, unmaskable sticky flag.
// - Supply overvoltage disables all, outputs low, unmaskable flag.
// - Buck output ok flag on both edges, separate masks, live status.
// - LDO output ok flag on both edges, separate masks, live status.
// - Power ok pin falling to inactive sets maskable flag; status shows.
// - Polarity inverts only the physical pin, not status or flag.
// - External clock appearing or vanishing sets maskable flag, status.
// - Detector enabled without clock raises the clock change flag.
// - Measurement done sets a maskable flag with no status.
// - Undervoltage lockout is the reset input; registers default, reset flag set unless masked.
// - On rising supply registers default and reset flag set unless masked.
// - Soft reset shuts down, restarts with defaults, sets reset flag unless masked.
// - Writing one to soft reset bit requests it; bit self-clears.

module pmic_protection_interrupts (
  // Clock and undervoltage lockout reset.
  input  wire        clock,
  input  wire        rst,
  // APB slave.
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Event inputs from analog monitors.
  input  wire [1:0]  buck_curlim_in,
  input  wire [1:0]  ldo_curlim_in,
  input  wire [1:0]  buck_low_in,
  input  wire [1:0]  ldo_low_in,
  input  wire [1:0]  buck_ok_in,
  input  wire [1:0]  ldo_ok_in,
  input  wire        hot_in,
  input  wire        overtemp_in,
  input  wire        overvolt_in,
  input  wire        power_ok_in,
  input  wire        sync_clock_in,
  input  wire        meas_done_in,
  input  wire        reset_mask_nv,
  // Regulator requests and enables.
  input  wire [1:0]  buck_enable_req,
  input  wire [1:0]  ldo_enable_req,
  input  wire        gpo_req_1,
  input  wire        gpo_req_2,
  output reg  [1:0]  buck_enable,
  output reg  [1:0]  ldo_enable,
  output reg         general_output_1,
  output reg         general_output_2,
  // Pins.
  output reg         power_ok_pin,
  output reg         irq_out_n,
  output reg         soft_reset_out
);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  localparam NSYNC = 20;
  wire [NSYNC-1:0] raw = {meas_done_in, sync_clock_in, power_ok_in,
                          overvolt_in, overtemp_in, hot_in, ldo_ok_in,
                          buck_ok_in, ldo_low_in, buck_low_in,
                          ldo_curlim_in, buck_curlim_in};
  reg  [NSYNC-1:0] sync_a;
  reg  [NSYNC-1:0] sync_b;
  reg  [NSYNC-1:0] last;

  // Two stages; only the second stage and its delayed copy are used.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_a <= 20'h00000;
      sync_b <= 20'h00000;
      last   <= 20'h00000;
    end else begin
      sync_a <= raw;
      sync_b <= sync_a;
      last   <= sync_b;
    end
  end

  wire [1:0] b_cl   = sync_b[1:0];
  wire [1:0] l_cl   = sync_b[3:2];
  wire [1:0] b_low  = sync_b[5:4];
  wire [1:0] l_low  = sync_b[7:6];
  wire [1:0] b_ok   = sync_b[9:8];
  wire [1:0] l_ok   = sync_b[11:10];
  wire       hot    = sync_b[12];
  wire       otemp  = sync_b[13];
  wire       ovolt  = sync_b[14];
  wire       pok    = sync_b[15];
  wire       sclk   = sync_b[16];
  wire       meas   = sync_b[17] & ~last[17];
  wire [1:0] b_rise = b_ok & ~last[9:8];
  wire [1:0] b_fall = ~b_ok & last[9:8];
  wire [1:0] l_rise = l_ok & ~last[11:10];
  wire [1:0] l_fall = ~l_ok & last[11:10];
  wire       pok_fall = ~pok & last[15];

  // ************************************************************
  // External clock detector
  // ************************************************************
  // A clock is present when an edge came within 64 cycles; the link
  // clock runs at 5 MHz, so 8 cycles per period is well inside that.
  reg [5:0] clk_idle;
  reg       clk_present;
  reg       clk_present_d;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      clk_idle      <= 6'h00;
      clk_present   <= 1'b0;
      clk_present_d <= 1'b0;
    end else begin
      clk_present_d <= clk_present;
      if (sclk != last[16]) begin
        clk_idle    <= 6'h00;
        clk_present <= 1'b1;
      end else if (clk_idle == 6'h3F) begin
        clk_present <= 1'b0;
      end else begin
        clk_idle <= clk_idle + 6'h01;
      end
    end
  end

  // ************************************************************
  // Registers and APB
  // ************************************************************
  reg  [8:0] mask_top;
  reg  [5:0] mask_buck;
  reg  [5:0] mask_ldo;
  reg  [1:0] ctrl;
  reg        reset_mask;
  reg        reset_mask_loaded;
  reg  [6:0] flag_top;
  reg  [5:0] flag_buck;
  reg  [5:0] flag_ldo;

  wire wr = psel & penable & pwrite & pready;

  wire hit = (paddr[11:2] <= 10'h008) && (paddr[1:0] == 2'b00);
  wire w_top  = wr && paddr == `OFS_INT_TOP;
  wire w_buck = wr && paddr == `OFS_INT_BUCK;
  wire w_ldo  = wr && paddr == `OFS_INT_LDO;
  wire [6:0] clr_top  = w_top  ? pwdata[6:0] : 7'h00;
  wire [5:0] clr_buck = w_buck ? pwdata[5:0] : 6'h00;
  wire [5:0] clr_ldo  = w_ldo  ? pwdata[5:0] : 6'h00;

  // Mask and control writes; the reset mask is not writable.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      mask_top  <= `RST_MASK_TOP;
      mask_buck <= `RST_MASK_REG;
      mask_ldo  <= `RST_MASK_REG;
      ctrl      <= `RST_CTRL;
    end else if (wr) begin
      if (paddr == `OFS_MASK_TOP)
        mask_top  <= pwdata[8:0];
      if (paddr == `OFS_MASK_BUCK)
        mask_buck <= pwdata[5:0];
      if (paddr == `OFS_MASK_LDO)
        mask_ldo  <= pwdata[5:0];
      if (paddr == `OFS_CTRL)
        ctrl      <= pwdata[1:0];
    end
  end

  // Nonvolatile mask is taken once after release of reset.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      reset_mask        <= 1'b0;
      reset_mask_loaded <= 1'b0;
    end else if (!reset_mask_loaded) begin
      reset_mask        <= reset_mask_nv;
      reset_mask_loaded <= 1'b1;
    end
  end

  // ************************************************************
  // Sticky flags
  // ************************************************************
  // Set wins over clear everywhere; a live level keeps its flag up.
  wire [1:0] b_short;
  wire [1:0] l_short;
  wire [6:0] set_top;
  assign set_top[`B_HOT_WARN]   = hot;
  assign set_top[`B_OVERTEMP]   = otemp;
  assign set_top[`B_OVERVOLT]   = ovolt;
  assign set_top[`B_PIN_OK]     = pok_fall;
  assign set_top[`B_CLK_CHANGE] = (clk_present ^ clk_present_d) |
                                  (ctrl[`B_CLKDET_EN] & ~clk_present);
  assign set_top[`B_MEAS_READY] = meas;
  assign set_top[`B_RESET_OCC]  = 1'b0; // Set at start-up below.
  wire [5:0] set_buck = {b_rise | b_fall, b_short, b_cl};
  wire [5:0] set_ldo  = {l_rise | l_fall, l_short, l_cl};

  // Start-up flag: set on the second cycle after reset when not masked,
  // which covers power-on, undervoltage recovery and soft reset.
  reg startup_done;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      flag_top     <= 7'h00;
      flag_buck    <= 6'h00;
      flag_ldo     <= 6'h00;
      startup_done <= 1'b0;
    end else begin
      startup_done <= reset_mask_loaded;
      flag_top  <= (flag_top & ~clr_top) | set_top;
      flag_buck <= (flag_buck & ~clr_buck) | set_buck;
      flag_ldo  <= (flag_ldo & ~clr_ldo) | set_ldo;
      if (reset_mask_loaded && !startup_done && !reset_mask)
        flag_top[`B_RESET_OCC] <= 1'b1;
    end
  end

  // Per-edge masks turn into one enable per output-ok flag.
  reg [1:0] b_ok_src;
  reg [1:0] l_ok_src;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      b_ok_src <= 2'b00;
      l_ok_src <= 2'b00;
    end else begin
      b_ok_src <= (b_rise & ~mask_buck[3:2]) | (b_fall & ~mask_buck[5:4]) |
                  (b_ok_src & ~(clr_buck[5:4] & ~(b_rise | b_fall)));
      l_ok_src <= (l_rise & ~mask_ldo[3:2]) | (l_fall & ~mask_ldo[5:4]) |
                  (l_ok_src & ~(clr_ldo[5:4] & ~(l_rise | l_fall)));
    end
  end

  // ************************************************************
  // Short detectors, one per regulator
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : shorts
      wire en_g  = (g < 2) ? buck_enable[g % 2] : ldo_enable[g % 2];
      wire low_g = (g < 2) ? b_low[g % 2] : l_low[g % 2];
      wire pulse_g;
      short_detector #(
        .WAIT_CYCLES (`SHORT_WAIT_CYC)
      ) u_short (
        .clock       (clock),
        .rst         (rst),
        .enabled     (en_g),
        .output_low  (low_g),
        .short_pulse (pulse_g)
      );
      if (g < 2) begin : b
        assign b_short[g] = pulse_g;
      end else begin : l
        assign l_short[g - 2] = pulse_g;
      end
    end
  endgenerate

  // ************************************************************
  // Interrupt pin and summaries
  // ************************************************************
  wire buck_pending = |flag_buck;
  wire ldo_pending  = |flag_ldo;
  wire top_any = |(flag_top & ~{1'b0, mask_top[5:4], mask_top[3], 2'b00,
                                mask_top[0]});
  wire reg_any = |(flag_buck[1:0] & ~mask_buck[1:0]) | |flag_buck[3:2] |
                 |b_ok_src | |(flag_ldo[1:0] & ~mask_ldo[1:0]) |
                 |flag_ldo[3:2] | |l_ok_src;

  // Pin is low while any unmasked flag is pending.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= ~(top_any | reg_any);
    end
  end

  // ************************************************************
  // Protection actions and power ok pin
  // ************************************************************
  // Shutdown paths override requests at once; a short latches off that
  // regulator until software clears the short flag.
  wire all_off = otemp | ovolt;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      buck_enable      <= 2'b00;
      ldo_enable       <= 2'b00;
      general_output_1 <= 1'b0;
      general_output_2 <= 1'b0;
      power_ok_pin     <= 1'b0;
    end else begin
      buck_enable <= all_off ? 2'b00 :
                     buck_enable_req & ~flag_buck[3:2] & ~b_short;
      ldo_enable  <= all_off ? 2'b00 :
                     ldo_enable_req & ~flag_ldo[3:2] & ~l_short;
      general_output_1 <= gpo_req_1 & ~all_off;
      general_output_2 <= gpo_req_2 & ~all_off;
      power_ok_pin <= pok ^ ctrl[`B_POLARITY];
    end
  end

  // ************************************************************
  // Soft reset request
  // ************************************************************
  // One-cycle request pulse; the bit never stores a one.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      soft_reset_out <= 1'b0;
    end else begin
      soft_reset_out <= wr && paddr == `OFS_RESET && pwdata[0];
    end
  end

  // ************************************************************
  // APB read and handshake
  // ************************************************************
  wire [12:0] status = {clk_present, pok, ovolt, otemp, hot,
                        l_ok, b_ok, l_cl, b_cl};
  reg  [31:0] rdata;
  always @* begin
    rdata = 32'h00000000;
    case (paddr)
      `OFS_INT_TOP:   rdata = {23'h0, ldo_pending, buck_pending, flag_top};
      `OFS_INT_BUCK:  rdata = {26'h0, flag_buck};
      `OFS_INT_LDO:   rdata = {26'h0, flag_ldo};
      `OFS_MASK_TOP:  rdata = {23'h0, mask_top[8:7], reset_mask,
                               mask_top[5:0]};
      `OFS_MASK_BUCK: rdata = {26'h0, mask_buck};
      `OFS_MASK_LDO:  rdata = {26'h0, mask_ldo};
      `OFS_STAT:      rdata = {19'h0, status};
      `OFS_CTRL:      rdata = {30'h0, ctrl};
      default:        rdata = 32'h00000000;
    endcase
  end

  // One wait state: pready is high in the second access cycle.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      if (psel & penable & ~pready & ~pwrite)
        prdata <= rdata;
    end
  end

endmodule // pmic_protection_interrupts

// ==== testbench/pmic_irq_chk.sv ====
/* Port checker of the protection interrupt block.
   Assumes the bind below. */
`timescale 1ns/1ps
`include "pmic_irq_defines.vh"
module pmic_irq_chk (
  // Clock, reset and bus.
  input wire        clock,
  input wire        rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  // Events and outputs.
  input wire        overtemp_in,
  input wire        overvolt_in,
  input wire        reset_mask_nv,
  input wire [1:0]  buck_enable,
  input wire [1:0]  ldo_enable,
  input wire        general_output_1,
  input wire        general_output_2,
  input wire        irq_out_n,
  input wire        soft_reset_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Faults held past the synchronisers.
  sequence heat_held; overtemp_in [*6]; endsequence
  sequence surge_held; overvolt_in [*6]; endsequence
  sequence all_off;
    buck_enable == 2'h0 && ldo_enable == 2'h0
      && !general_output_1 && !general_output_2;
  endsequence
  sequence soft_req;
    psel && penable && pwrite && !pready
      && paddr == `OFS_RESET && pwdata[0];
  endsequence
  // One-cycle bus answer.
  bus_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready too long");
  error_qualified_a: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  // Shutdowns hold while a fault stands.
  heat_off_a: assert property (heat_held |-> all_off)
    else $error("outputs on in overtemp");
  heat_irq_a: assert property (heat_held |-> !irq_out_n)
    else $error("no irq in overtemp");
  surge_off_a: assert property (surge_held |-> all_off)
    else $error("outputs on in overvolt");
  surge_irq_a: assert property (surge_held |-> !irq_out_n)
    else $error("no irq in overvolt");
  // Start-up flags the reset unless masked.
  wake_flag_a: assert property (
    $fell(rst) && !reset_mask_nv |-> ##[1:4] !irq_out_n)
    else $error("no reset irq");
  soft_pulse_a: assert property (
    soft_req |-> ##[1:3] soft_reset_out) else $error("no soft reset");
  soft_single_a: assert property (
    soft_reset_out |=> !soft_reset_out) else $error("soft reset too long");
endmodule // pmic_irq_chk

bind pmic_protection_interrupts pmic_irq_chk pmic_irq_chk_inst (
  .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .overtemp_in, .overvolt_in, .reset_mask_nv, .buck_enable,
  .ldo_enable, .general_output_1, .general_output_2, .irq_out_n,
  .soft_reset_out);

// ==== testbench/apb_host.sv ====
/* Host model: APB master that reads and clears flags.
   Assumes one caller at a time. */
`timescale 1ns/1ps
module apb_host (
  // Clock.
  input  wire        clock,
  // Request.
  output reg         psel,
  output reg         penable,
  output reg         pwrite,
  output reg  [11:0] paddr,
  output reg  [31:0] pwdata,
  // Answer.
  input  wire [31:0] prdata,
  input  wire        pready,
  input  wire        pslverr
);
  // The bus is idle from time zero.
  initial {psel, penable, pwrite, paddr, pwdata} = 47'h0;
  // One transfer; after pready the address and data are scrambled so
  // nothing leans on stale values.
  task xfer(input w, input [11:0] a, input [31:0] d,
            output [31:0] r, output e);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // apb_host

// ==== testbench/pmic_protection_interrupts_tb.sv ====
/* Self-checking bench of the protection interrupt block.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ps
`include "pmic_irq_defines.vh"
module pmic_protection_interrupts_tb;
  reg         clock, rst, clk_run, er;
  wire        psel, penable, pwrite, pready, pslverr;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  reg  [1:0]  buck_curlim_in, ldo_curlim_in, buck_low_in, ldo_low_in;
  reg  [1:0]  buck_ok_in, ldo_ok_in, buck_enable_req, ldo_enable_req;
  reg         hot_in, overtemp_in, overvolt_in, power_ok_in;
  reg         sync_clock_in, meas_done_in, reset_mask_nv;
  reg         gpo_req_1, gpo_req_2;
  wire [1:0]  buck_enable, ldo_enable;
  wire        general_output_1, general_output_2, power_ok_pin;
  wire        irq_out_n, soft_reset_out;
  integer     err_count, total_checks, cycles, k, soft_seen;
  reg  [31:0] rd;

  pmic_protection_interrupts pmic_protection_interrupts_inst (
    .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .buck_curlim_in, .ldo_curlim_in, .buck_low_in,
    .ldo_low_in, .buck_ok_in, .ldo_ok_in, .hot_in, .overtemp_in,
    .overvolt_in, .power_ok_in, .sync_clock_in, .meas_done_in,
    .reset_mask_nv, .buck_enable_req, .ldo_enable_req, .gpo_req_1,
    .gpo_req_2, .buck_enable, .ldo_enable, .general_output_1,
    .general_output_2, .power_ok_pin, .irq_out_n, .soft_reset_out);
  apb_host apb_host_inst (.clock, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr);

  // 40 MHz clock.
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Hang limit, 200 ns sync clock parked low when off, soft pulse count.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 50000) begin
      err_count = err_count + 1;
      results;
    end
    if (cycles % 4 == 0) sync_clock_in <= clk_run & ~sync_clock_in;
    if (soft_reset_out === 1'b1) soft_seen <= soft_seen + 1;
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task results;
    if (err_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    total_checks = total_checks + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clock);
  endtask
  task wr(input [11:0] a, input [31:0] d);
    apb_host_inst.xfer(1'b1, a, d, rd, er);
  endtask
  task rdc(input string nm, input [11:0] a, input [31:0] e);
    apb_host_inst.xfer(1'b0, a, 32'h0, rd, er);
    chk(nm, e, rd);
  endtask
  task do_reset(input nv);
    reset_mask_nv <= nv;
    rst <= 1'b1;
    cyc(10);
    rst <= 1'b0;
    cyc(6);
  endtask
  task set_ev(input integer n, input v);
    case (n)
      0: buck_curlim_in[0] <= v;
      1: ldo_curlim_in[1] <= v;
      2: hot_in <= v;
      3: overtemp_in <= v;
      4: overvolt_in <= v;
      5: buck_ok_in[1] <= v;
      default: ldo_ok_in[0] <= v;
    endcase
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task t_start;
    rdc("rst flag", `OFS_INT_TOP, 32'h40);
    chk("irq start", 32'h0, irq_out_n);
    rdc("top mask", `OFS_MASK_TOP, 32'h0);
    wr(`OFS_INT_TOP, 32'h40);
    rdc("rst clr", `OFS_INT_TOP, 32'h0);
    chk("irq clr", 32'h1, irq_out_n);
  endtask
  // Flag stays while its cause stands, then clears.
  task t_sticky(input integer n, input [11:0] a,
                input [31:0] f, s, top);
    set_ev(n, 1'b1);
    cyc(6);
    rdc("flag", a, f);
    rdc("status", `OFS_STAT, s);
    rdc("sum", `OFS_INT_TOP, top);
    chk("irq", 32'h0, irq_out_n);
    wr(a, f);
    rdc("held", a, f);
    if (n > 2) chk("shutdown", 32'h0, {buck_enable, ldo_enable,
        general_output_1, general_output_2});
    set_ev(n, 1'b0);
    cyc(6);
    wr(a, f);
    rdc("cleared", a, 32'h0);
    rdc("sum clr", `OFS_INT_TOP, 32'h0);
    chk("irq off", 32'h1, irq_out_n);
  endtask
  // Both output-ok edges set one flag; r is the pin after the rise.
  task t_ok(input integer n, input [11:0] ai, am,
            input [31:0] m, f, s, input r);
    wr(am, m);
    set_ev(n, 1'b1);
    cyc(6);
    rdc("ok rise", ai, f);
    rdc("ok stat", `OFS_STAT, s);
    chk("rise irq", {31'h0, r}, irq_out_n);
    wr(ai, f);
    set_ev(n, 1'b0);
    cyc(6);
    rdc("ok fall", ai, f);
    chk("fall irq", {31'h0, !r}, irq_out_n);
    wr(ai, f);
    wr(am, 32'h0);
    cyc(3);
    chk("ok idle", 32'h1, irq_out_n);
  endtask
  task t_masked;
    wr(`OFS_MASK_TOP, 32'h1);
    hot_in <= 1'b1;
    cyc(6);
    rdc("masked", `OFS_INT_TOP, 32'h1);
    chk("masked irq", 32'h1, irq_out_n);
    hot_in <= 1'b0;
    cyc(6);
    wr(`OFS_INT_TOP, 32'h1);
    wr(`OFS_MASK_TOP, 32'h0);
  endtask
  task t_pin;
    power_ok_in <= 1'b1;
    cyc(6);
    chk("pin high", 32'h1, power_ok_pin);
    rdc("no rise", `OFS_INT_TOP, 32'h0);
    wr(`OFS_CTRL, 32'h1);
    cyc(3);
    chk("pin inv", 32'h0, power_ok_pin);
    rdc("pin stat", `OFS_STAT, 32'h800);
    power_ok_in <= 1'b0;
    cyc(6);
    rdc("pin flag", `OFS_INT_TOP, 32'h8);
    chk("pin irq", 32'h0, irq_out_n);
    wr(`OFS_INT_TOP, 32'h8);
    wr(`OFS_CTRL, 32'h0);
  endtask
  task t_clk;
    clk_run <= 1'b1;
    cyc(40);
    rdc("clk on", `OFS_INT_TOP, 32'h10);
    rdc("clk stat", `OFS_STAT, 32'h1000);
    wr(`OFS_INT_TOP, 32'h10);
    clk_run <= 1'b0;
    cyc(90);
    rdc("clk lost", `OFS_INT_TOP, 32'h10);
    rdc("clk gone", `OFS_STAT, 32'h0);
    wr(`OFS_INT_TOP, 32'h10);
    wr(`OFS_CTRL, 32'h2);
    cyc(90);
    rdc("det flag", `OFS_INT_TOP, 32'h10);
    chk("det irq", 32'h0, irq_out_n);
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_INT_TOP, 32'h10);
  endtask
  task t_meas;
    meas_done_in <= 1'b1;
    cyc(2);
    meas_done_in <= 1'b0;
    cyc(6);
    rdc("meas flag", `OFS_INT_TOP, 32'h20);
    rdc("meas stat", `OFS_STAT, 32'h0);
    wr(`OFS_INT_TOP, 32'h20);
    rdc("meas clr", `OFS_INT_TOP, 32'h0);
  endtask
  task t_bad;
    apb_host_inst.xfer(1'b0, 12'h024, 32'h0, rd, er);
    chk("bad err", 32'h1, {31'h0, er});
    chk("bad data", 32'h0, rd);
  endtask
  task t_short;
    buck_low_in[0] <= 1'b1;
    k = 0;
    while (buck_enable[0] !== 1'b0 && k < 41000) begin
      cyc(1);
      k = k + 1;
    end
    chk("short delay", 32'h1, k > 39990 && k < 40010);
    rdc("short flag", `OFS_INT_BUCK, 32'h4);
    chk("short irq", 32'h0, irq_out_n);
    buck_low_in[0] <= 1'b0;
    wr(`OFS_INT_BUCK, 32'h4);
    cyc(3);
    chk("restart", 32'h3, buck_enable);
  endtask
  task t_soft;
    wr(`OFS_RESET, 32'h1);
    cyc(3);
    chk("soft pulses", 32'h1, soft_seen);
    rdc("soft bit", `OFS_RESET, 32'h0);
    do_reset(1'b1);
    rdc("masked reset", `OFS_INT_TOP, 32'h0);
    chk("irq quiet", 32'h1, irq_out_n);
    wr(`OFS_MASK_TOP, 32'h0);
    rdc("reset mask", `OFS_MASK_TOP, 32'h40);
  endtask

  // Main sequence.
  initial begin
    {buck_curlim_in, ldo_curlim_in, buck_low_in} = 6'h00;
    {ldo_low_in, buck_ok_in, ldo_ok_in} = 6'h00;
    {hot_in, overtemp_in, overvolt_in, power_ok_in} = 4'h0;
    {sync_clock_in, meas_done_in, reset_mask_nv, clk_run} = 4'h0;
    {buck_enable_req, ldo_enable_req, gpo_req_1, gpo_req_2} = 6'h3F;
    {err_count, total_checks, cycles, soft_seen} = 128'h0;
    do_reset(1'b0);
    t_start;
    t_sticky(0, `OFS_INT_BUCK, 32'h1, 32'h1, 32'h80);
    t_sticky(1, `OFS_INT_LDO, 32'h2, 32'h8, 32'h100);
    t_sticky(2, `OFS_INT_TOP, 32'h1, 32'h100, 32'h1);
    t_sticky(3, `OFS_INT_TOP, 32'h2, 32'h200, 32'h2);
    t_sticky(4, `OFS_INT_TOP, 32'h4, 32'h400, 32'h4);
    t_masked;
    t_ok(5, `OFS_INT_BUCK, `OFS_MASK_BUCK, 32'h8, 32'h20, 32'h20,
         1'b1);
    t_ok(6, `OFS_INT_LDO, `OFS_MASK_LDO, 32'h10, 32'h10, 32'h40,
         1'b0);
    t_pin;
    t_clk;
    t_meas;
    t_bad;
    t_short;
    t_soft;
    results;
  end
endmodule // pmic_protection_interrupts_tb
